/* File: pkg/fbp_pkg.sv */
// shared constants and types for the fast-program flash bank and its host
package fbp_pkg;
	localparam int AW = 12;
	localparam int DW = 16;
	localparam int TW = 16;
	localparam int NSEC = 4;
	localparam int SEC_HI = 11;
	localparam int SEC_LO = 10;
	localparam int SEC_W = 2;
	localparam int LOW_W = 2;
	localparam int IDX_W = 4;
	localparam int NWORD = 16;

	localparam logic [AW-1:0] OFS_UNLK1 = 12'h555;
	localparam logic [AW-1:0] OFS_UNLK2 = 12'h2aa;
	localparam logic [AW-1:0] OFS_BASE = 12'h000;

	localparam logic [DW-1:0] D_UNLK1 = 16'h00aa;
	localparam logic [DW-1:0] D_UNLK2 = 16'h0055;
	localparam logic [DW-1:0] D_ENTRY = 16'h0020;
	localparam logic [DW-1:0] D_SETUP = 16'h00a0;
	localparam logic [DW-1:0] D_EXIT1 = 16'h0090;
	localparam logic [DW-1:0] D_EXIT2 = 16'h0000;
	localparam logic [DW-1:0] D_ERSET = 16'h0080;
	localparam logic [DW-1:0] D_GO = 16'h0030;
	localparam logic [DW-1:0] D_SUSP = 16'h00b0;
	localparam logic [DW-1:0] D_RESET = 16'h00f0;
	localparam logic [DW-1:0] ERASED = 16'hffff;

	localparam int POLL_BIT = 7;
	localparam int TOG1_BIT = 6;
	localparam int LIMIT_BIT = 5;
	localparam int TOG2_BIT = 2;

	localparam logic [TW-1:0] PROG_CYC_DEF = 16'h0010;
	localparam logic [TW-1:0] ERASE_CYC_DEF = 16'h0040;
	localparam logic [TW-1:0] PROT_PROG_CYC_DEF = 16'h0008;
	localparam logic [TW-1:0] ALL_PROT_CYC_DEF = 16'h0020;

	localparam logic [2:0] WE_LOW_CYC = 3'h2;
	localparam logic [2:0] GAP_CYC = 3'h2;
	localparam logic [2:0] OE_LOW_CYC = 3'h3;

	localparam logic [3:0] REG_CMD = 4'h0;
	localparam logic [3:0] REG_ADDR = 4'h1;
	localparam logic [3:0] REG_DATA = 4'h2;
	localparam logic [3:0] REG_STAT = 4'h3;
	localparam logic [3:0] REG_RDATA = 4'h4;
	localparam int ST_BUSY = 0;
	localparam int ST_DONE = 1;
	localparam int ST_FAIL = 2;

	localparam logic [3:0] OP_ENTER = 4'h1;
	localparam logic [3:0] OP_PROG = 4'h2;
	localparam logic [3:0] OP_EXIT = 4'h3;
	localparam logic [3:0] OP_ERASE = 4'h4;
	localparam logic [3:0] OP_SUSP = 4'h5;
	localparam logic [3:0] OP_RESUME = 4'h6;
	localparam logic [3:0] OP_RESET = 4'h7;
	localparam logic [3:0] OP_READ = 4'h8;

	typedef enum logic [12:0] {
		S_READ = 13'h0001,
		S_U1 = 13'h0002,
		S_U2 = 13'h0004,
		S_BYP = 13'h0008,
		S_BPSET = 13'h0010,
		S_BEXIT = 13'h0020,
		S_BERSET = 13'h0040,
		S_PROG = 13'h0080,
		S_ERASE = 13'h0100,
		S_ESUS = 13'h0200,
		S_SPSET = 13'h0400,
		S_SPROG = 13'h0800,
		S_FAIL = 13'h1000
	} fbp_dstate_e;

	typedef enum logic [4:0] {
		H_IDLE = 5'h01,
		H_WLO = 5'h02,
		H_WHI = 5'h04,
		H_RLO = 5'h08,
		H_RHI = 5'h10
	} fbp_hstate_e;
endpackage : fbp_pkg

/* File: pkg/fbp_if.sv */
// flash bus between host controller and flash bank
`timescale 1ns/1ns
`default_nettype none
interface fbp_if;
	import fbp_pkg::*;
	logic [AW-1:0] addr;
	logic ce_n;
	logic oe_n;
	logic we_n;
	logic [DW-1:0] h_dq;
	logic h_dq_oe;
	logic [DW-1:0] d_dq;
	logic d_dq_oe;
	logic [DW-1:0] dq;

	// undriven bus floats high like a pulled-up data bus
	assign dq = d_dq_oe ? d_dq : (h_dq_oe ? h_dq : ERASED);

	modport dev (
		input addr, ce_n, oe_n, we_n, dq,
		output d_dq, d_dq_oe
	);
	modport host (
		output addr, ce_n, oe_n, we_n, h_dq, h_dq_oe,
		input dq
	);
endinterface : fbp_if
`default_nettype wire

/* File: hw/fbp_timer.sv */
// down counter for embedded operation intervals
`timescale 1ns/1ns
`default_nettype none
module fbp_timer (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic i_load,
	input wire logic [fbp_pkg::TW-1:0] i_count,
	input wire logic i_run,
	output logic o_done
);
	import fbp_pkg::*;
	logic [TW-1:0] cnt;

	// holding while not running lets a suspended erase pick up where it left
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			cnt <= '0;
		end else if (i_load) begin
			cnt <= i_count;
		end else if (i_run && cnt != '0) begin
			cnt <= cnt - 1'b1;
		end
	end

	assign o_done = i_run && !i_load && cnt == TW'(1);
endmodule : fbp_timer
`default_nettype wire

/* File: hw/fbp_flash.sv */
// flash bank command sequencer with fast-program mode and status bits
// Operation
// - enter mode: AA@555, 55@2AA, 20@555
// - program: A0 anywhere, then data at target
// - fast mode ignores all other commands
// - exit: 90 then 00, back to read
// - poll valid after final write strobe rise
// - programming reads inverted bit 7 until done
// - host polls at program or erase address
// - erase polls 0, done or suspended 1
// - protected program: busy interval, array untouched
// - all-protected erase: busy interval, nothing erased
// - bit 7 may settle before bits 6-0
// - toggle one flips per read while busy
// - all-protected erase toggles for its interval
// - protected program toggles for its interval
// - toggle one halts in suspend, runs in suspend-program
// - toggle changes only between distinct read accesses
// - toggle two flips reading erase-selected sectors
// - host starts polling with two reads
// - persistent toggle plus limit flag means reset
// - interrupted polling restarts with double read
// - limit flag reads 1 on failed operation
//
// The implementer's own choices: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ns
`default_nettype none
module fbp_flash #(
	parameter logic [fbp_pkg::TW-1:0] PROG_CYC = fbp_pkg::PROG_CYC_DEF,
	parameter logic [fbp_pkg::TW-1:0] ERASE_CYC = fbp_pkg::ERASE_CYC_DEF,
	parameter logic [fbp_pkg::TW-1:0] PROT_PROG_CYC =
		fbp_pkg::PROT_PROG_CYC_DEF,
	parameter logic [fbp_pkg::TW-1:0] ALL_PROT_CYC =
		fbp_pkg::ALL_PROT_CYC_DEF
) (
	input wire logic i_mclk,
	input wire logic i_rstn,
	fbp_if.dev bus,
	input wire logic [fbp_pkg::NSEC-1:0] i_sector_protect,
	output logic o_bypass,
	output logic o_busy,
	output logic o_limit
);
	import fbp_pkg::*;

	fbp_dstate_e state, next_state;
	logic wr_act, wr_act_q, wr_end;
	logic rd_act, rd_act_q, rd_start;
	logic [AW-1:0] ca;
	logic [DW-1:0] cd;
	logic [SEC_W-1:0] wsec, rsec, e_sec;
	logic [IDX_W-1:0] widx, ridx, p_idx;
	logic wprot, p_prot, p_bad, e_prot;
	logic [DW-1:0] p_data;
	logic [DW-1:0] mem [0:NWORD-1];
	logic limit, fail_susp, tog1, tog2;
	logic op_load, op_done, op_run, er_load, er_done, er_run;
	logic [TW-1:0] op_count, er_count;
	logic in_esec, status_rd, tog1_on, tog2_on, poll;
	logic [DW-1:0] st_word, rd_word, dq_q;

	assign wr_act = !bus.ce_n && !bus.we_n;
	assign wr_end = wr_act_q && !wr_act;
	assign rd_act = !bus.ce_n && !bus.oe_n && bus.we_n;
	assign rd_start = rd_act && !rd_act_q;

	assign wsec = ca[SEC_HI:SEC_LO];
	assign widx = {wsec, ca[LOW_W-1:0]};
	assign rsec = bus.addr[SEC_HI:SEC_LO];
	assign ridx = {rsec, bus.addr[LOW_W-1:0]};
	assign wprot = i_sector_protect[wsec];

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			wr_act_q <= 1'b0;
			rd_act_q <= 1'b0;
		end else begin
			wr_act_q <= wr_act;
			rd_act_q <= rd_act;
		end
	end

	// last address and data seen while the strobe was low count
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			ca <= '0;
			cd <= '0;
		end else if (wr_act) begin
			ca <= bus.addr;
			cd <= bus.dq;
		end
	end

	always_comb begin
		next_state = state;
		op_load = 1'b0;
		er_load = 1'b0;
		// commands act on the rising write strobe
		case (state)
		S_READ: begin
			if (wr_end && cd == D_UNLK1 && ca == OFS_UNLK1) begin
				next_state = S_U1;
			end
		end
		S_U1: begin
			if (wr_end) begin
				next_state = (cd == D_UNLK2 && ca == OFS_UNLK2) ?
					S_U2 : S_READ;
			end
		end
		S_U2: begin
			if (wr_end) begin
				next_state = (cd == D_ENTRY && ca == OFS_UNLK1) ?
					S_BYP : S_READ;
			end
		end
		S_BYP: begin
			if (wr_end) begin
				case (cd)
				D_SETUP: next_state = S_BPSET;
				D_EXIT1: next_state = S_BEXIT;
				D_ERSET: next_state = S_BERSET;
				default: next_state = S_BYP;
				endcase
			end
		end
		S_BPSET: begin
			if (wr_end) begin
				op_load = 1'b1;
				next_state = S_PROG;
			end
		end
		S_BEXIT: begin
			if (wr_end) begin
				next_state = (cd == D_EXIT2) ? S_READ : S_BYP;
			end
		end
		S_BERSET: begin
			if (wr_end && cd == D_GO) begin
				er_load = 1'b1;
				next_state = S_ERASE;
			end else if (wr_end) begin
				next_state = S_BYP;
			end
		end
		S_PROG: begin
			if (op_done) begin
				next_state = p_bad ? S_FAIL : S_BYP;
			end
		end
		S_ERASE: begin
			if (er_done) begin
				next_state = S_BYP;
			end else if (wr_end && cd == D_SUSP) begin
				next_state = S_ESUS;
			end
		end
		S_ESUS: begin
			if (wr_end && cd == D_SETUP) begin
				next_state = S_SPSET;
			end else if (wr_end && cd == D_GO) begin
				next_state = S_ERASE;
			end
		end
		S_SPSET: begin
			// the suspended sector itself cannot be programmed
			if (wr_end && wsec != e_sec) begin
				op_load = 1'b1;
				next_state = S_SPROG;
			end else if (wr_end) begin
				next_state = S_ESUS;
			end
		end
		S_SPROG: begin
			if (op_done) begin
				next_state = p_bad ? S_FAIL : S_ESUS;
			end
		end
		S_FAIL: begin
			if (wr_end && cd == D_RESET) begin
				next_state = fail_susp ? S_ESUS : S_READ;
			end
		end
		default: next_state = S_READ;
		endcase
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= S_READ;
		end else begin
			state <= next_state;
		end
	end

	assign op_count = wprot ? PROT_PROG_CYC : PROG_CYC;
	assign er_count = wprot ? ALL_PROT_CYC : ERASE_CYC;
	assign op_run = state == S_PROG || state == S_SPROG;
	assign er_run = state == S_ERASE;

	fbp_timer u_op_timer (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_load(op_load),
		.i_count(op_count),
		.i_run(op_run),
		.o_done(op_done)
	);

	fbp_timer u_er_timer (
		.i_mclk(i_mclk),
		.i_rstn(i_rstn),
		.i_load(er_load),
		.i_count(er_count),
		.i_run(er_run),
		.o_done(er_done)
	);

	// a bit cannot be raised by programming; that exhausts the pulse count
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			p_idx <= '0;
			p_data <= '0;
			p_prot <= 1'b0;
			p_bad <= 1'b0;
		end else if (op_load) begin
			p_idx <= widx;
			p_data <= cd;
			p_prot <= wprot;
			p_bad <= !wprot && |(~mem[widx] & cd);
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			e_sec <= '0;
			e_prot <= 1'b0;
		end else if (er_load) begin
			e_sec <= wsec;
			e_prot <= wprot;
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			for (int i = 0; i < NWORD; i++) begin
				mem[i] <= ERASED;
			end
		end else begin
			if (op_run && op_done && !p_prot && !p_bad) begin
				mem[p_idx] <= p_data;
			end
			if (er_done && !e_prot) begin
				for (int i = 0; i < NWORD; i++) begin
					if (SEC_W'(i >> LOW_W) == e_sec) begin
						mem[i] <= ERASED;
					end
				end
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			limit <= 1'b0;
			fail_susp <= 1'b0;
		end else if (op_run && op_done && p_bad) begin
			limit <= 1'b1;
			fail_susp <= state == S_SPROG;
		end else if (state == S_FAIL && wr_end && cd == D_RESET) begin
			limit <= 1'b0;
		end
	end

	assign in_esec = rsec == e_sec;
	assign tog1_on = op_run || er_run || state == S_FAIL;
	assign tog2_on = in_esec && (er_run || state == S_ESUS ||
		state == S_SPROG);
	assign status_rd = tog1_on || (state == S_ESUS && in_esec);

	always_comb begin
		if (er_run) begin
			poll = 1'b0;
		end else if (state == S_ESUS) begin
			poll = 1'b1;
		end else begin
			poll = ~p_data[POLL_BIT];
		end
		st_word = '0;
		st_word[POLL_BIT] = poll;
		st_word[TOG1_BIT] = tog1;
		st_word[LIMIT_BIT] = limit;
		st_word[TOG2_BIT] = tog2;
		rd_word = status_rd ? st_word : mem[ridx];
	end

	// flipping only at an access start keeps one read steady
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			tog1 <= 1'b0;
			tog2 <= 1'b0;
		end else if (rd_start) begin
			if (tog1_on) begin
				tog1 <= ~tog1;
			end
			if (tog2_on) begin
				tog2 <= ~tog2;
			end
		end
	end

	// only bit 7 follows the array mid-access; the rest wait for a new read
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			dq_q <= '0;
		end else if (rd_start) begin
			dq_q <= rd_word;
		end else if (rd_act) begin
			dq_q[POLL_BIT] <= rd_word[POLL_BIT];
		end
	end

	assign bus.d_dq = dq_q;
	assign bus.d_dq_oe = rd_act && rd_act_q;
	assign o_bypass = !(state == S_READ || state == S_U1 || state == S_U2);
	assign o_busy = tog1_on;
	assign o_limit = limit;
endmodule : fbp_flash
`default_nettype wire

/* File: hw/fbp_host.sv */
// host controller issuing flash command sequences and toggle polling
`timescale 1ns/1ns
`default_nettype none
module fbp_host (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [3:0] i_reg_addr,
	input wire logic [fbp_pkg::DW-1:0] i_reg_wdata,
	input wire logic i_reg_wr,
	input wire logic i_reg_rd,
	output logic [fbp_pkg::DW-1:0] o_reg_rdata,
	fbp_if.host bus
);
	import fbp_pkg::*;

	fbp_hstate_e state;
	logic [2:0] hcnt;
	logic [1:0] step, seq_n;
	logic [AW-1:0] seq_a [0:2];
	logic [DW-1:0] seq_d [0:2];
	logic [AW-1:0] r_addr;
	logic [DW-1:0] r_data, r_rdata, smp;
	logic poll_en, read_en, pcnt, prev6, chk5, fin, fail_evt;
	logic done, fail, busy, start, wr_ph;
	logic [DW-1:0] stat_word;

	assign busy = state != H_IDLE;
	assign start = i_reg_wr && i_reg_addr == REG_CMD && !busy;
	assign wr_ph = state == H_WLO || state == H_WHI;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			state <= H_IDLE;
			hcnt <= '0;
			step <= '0;
			seq_n <= '0;
			for (int i = 0; i < 3; i++) begin
				seq_a[i] <= '0;
				seq_d[i] <= '0;
			end
			poll_en <= 1'b0;
			read_en <= 1'b0;
			pcnt <= 1'b0;
			prev6 <= 1'b0;
			chk5 <= 1'b0;
			smp <= '0;
			fin <= 1'b0;
			fail_evt <= 1'b0;
		end else begin
			fin <= 1'b0;
			fail_evt <= 1'b0;
			hcnt <= hcnt - 3'h1;
			case (state)
			H_IDLE: begin
				hcnt <= WE_LOW_CYC;
				step <= '0;
				pcnt <= 1'b0;
				chk5 <= 1'b0;
				poll_en <= 1'b0;
				read_en <= 1'b0;
				if (start) begin
					state <= H_WLO;
					seq_n <= 2'h1;
					seq_a[0] <= OFS_BASE;
					seq_a[1] <= OFS_BASE;
					case (i_reg_wdata[3:0])
					OP_ENTER: begin
						seq_n <= 2'h3;
						seq_a[0] <= OFS_UNLK1;
						seq_d[0] <= D_UNLK1;
						seq_a[1] <= OFS_UNLK2;
						seq_d[1] <= D_UNLK2;
						seq_a[2] <= OFS_UNLK1;
						seq_d[2] <= D_ENTRY;
					end
					OP_PROG: begin
						seq_n <= 2'h2;
						seq_a[0] <= r_addr;
						seq_d[0] <= D_SETUP;
						seq_a[1] <= r_addr;
						seq_d[1] <= r_data;
						poll_en <= 1'b1;
					end
					OP_EXIT: begin
						seq_n <= 2'h2;
						seq_d[0] <= D_EXIT1;
						seq_d[1] <= D_EXIT2;
					end
					OP_ERASE: begin
						seq_n <= 2'h2;
						seq_d[0] <= D_ERSET;
						seq_a[1] <= r_addr;
						seq_d[1] <= D_GO;
						poll_en <= 1'b1;
					end
					OP_SUSP: seq_d[0] <= D_SUSP;
					OP_RESUME: seq_d[0] <= D_GO;
					OP_RESET: seq_d[0] <= D_RESET;
					OP_READ: begin
						read_en <= 1'b1;
						hcnt <= OE_LOW_CYC;
						state <= H_RLO;
					end
					default: state <= H_IDLE;
					endcase
				end
			end
			H_WLO: begin
				if (hcnt == 3'h1) begin
					hcnt <= GAP_CYC;
					state <= H_WHI;
				end
			end
			H_WHI: begin
				if (hcnt == 3'h1) begin
					if (step + 2'h1 < seq_n) begin
						step <= step + 2'h1;
						hcnt <= WE_LOW_CYC;
						state <= H_WLO;
					end else if (poll_en || read_en) begin
						hcnt <= OE_LOW_CYC;
						state <= H_RLO;
					end else begin
						fin <= 1'b1;
						state <= H_IDLE;
					end
				end
			end
			H_RLO: begin
				if (hcnt == 3'h1) begin
					smp <= bus.dq;
					hcnt <= GAP_CYC;
					state <= H_RHI;
				end
			end
			H_RHI: begin
				if (hcnt == 3'h1) begin
					hcnt <= OE_LOW_CYC;
					state <= H_RLO;
					if (!poll_en) begin
						fin <= 1'b1;
						state <= H_IDLE;
					end else if (!pcnt) begin
						prev6 <= smp[TOG1_BIT];
						pcnt <= 1'b1;
					end else if (smp[TOG1_BIT] == prev6) begin
						fin <= 1'b1;
						state <= H_IDLE;
					end else if (chk5) begin
						// still toggling after the limit flag: give up
						fail_evt <= 1'b1;
						poll_en <= 1'b0;
						step <= '0;
						seq_n <= 2'h1;
						seq_a[0] <= OFS_BASE;
						seq_d[0] <= D_RESET;
						hcnt <= WE_LOW_CYC;
						state <= H_WLO;
					end else begin
						chk5 <= smp[LIMIT_BIT];
						pcnt <= 1'b0;
					end
				end
			end
			default: state <= H_IDLE;
			endcase
		end
	end

	// polling always reads at the program or sector address
	assign bus.addr = wr_ph ? seq_a[step] : r_addr;
	assign bus.h_dq = seq_d[step];
	assign bus.h_dq_oe = wr_ph;
	assign bus.ce_n = !(state == H_WLO || state == H_RLO);
	assign bus.we_n = state != H_WLO;
	assign bus.oe_n = state != H_RLO;

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			r_addr <= '0;
			r_data <= '0;
		end else if (i_reg_wr && i_reg_addr == REG_ADDR) begin
			r_addr <= i_reg_wdata[AW-1:0];
		end else if (i_reg_wr && i_reg_addr == REG_DATA) begin
			r_data <= i_reg_wdata;
		end
	end

	// a finishing read also refreshes the result word
	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			done <= 1'b0;
			fail <= 1'b0;
			r_rdata <= '0;
		end else begin
			if (fin) begin
				done <= 1'b1;
				r_rdata <= smp;
			end else if (start) begin
				done <= 1'b0;
			end
			if (fail_evt) begin
				fail <= 1'b1;
			end else if (start) begin
				fail <= 1'b0;
			end
		end
	end

	always_comb begin
		stat_word = '0;
		stat_word[ST_BUSY] = busy;
		stat_word[ST_DONE] = done;
		stat_word[ST_FAIL] = fail;
	end

	always_ff @(posedge i_mclk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_reg_rdata <= '0;
		end else if (i_reg_rd) begin
			case (i_reg_addr)
			REG_ADDR: o_reg_rdata <= {{(DW-AW){1'b0}}, r_addr};
			REG_DATA: o_reg_rdata <= r_data;
			REG_STAT: o_reg_rdata <= stat_word;
			REG_RDATA: o_reg_rdata <= r_rdata;
			default: o_reg_rdata <= '0;
			endcase
		end else begin
			o_reg_rdata <= '0;
		end
	end
endmodule : fbp_host
`default_nettype wire

/* File: sim/fbp_checker.sv */
// concurrent checks on the flash bus joining host and bank
`timescale 1ns/1ns
`default_nettype none
module fbp_checker (
	input wire logic i_mclk,
	input wire logic i_rstn,
	input wire logic [fbp_pkg::AW-1:0] addr,
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [fbp_pkg::DW-1:0] h_dq,
	input wire logic h_dq_oe,
	input wire logic [fbp_pkg::DW-1:0] d_dq,
	input wire logic d_dq_oe,
	input wire logic [fbp_pkg::DW-1:0] dq
);
	import fbp_pkg::*;
	wire logic rd_act;
	assign rd_act = !ce_n && !oe_n && we_n;
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (!i_rstn);

	// both ends driving at once would corrupt every transfer
	no_contention_a: assert property (!(d_dq_oe && h_dq_oe))
		else $error("bank and host drive the data bus together");
	dev_in_read_a: assert property (d_dq_oe |-> rd_act)
		else $error("bank drives outside a read access");
	answer_delay_a: assert property ($rose(rd_act) |->
		!d_dq_oe ##1 d_dq_oe)
		else $error("bank answer not in second access cycle");
	// bits 6-0 may not move inside one access
	frozen_low_a: assert property (d_dq_oe && $past(d_dq_oe) |->
		d_dq[6:0] == $past(d_dq[6:0]))
		else $error("low status bits moved within one access");
	write_pulse_a: assert property ($fell(we_n) |->
		(!ce_n && h_dq_oe)[*2] ##1 we_n)
		else $error("write strobe not two cycles with data");
	write_gap_a: assert property ($rose(we_n) |->
		(we_n && h_dq_oe)[*2])
		else $error("write data released too early");
	// the bank latches whatever stands in the last low cycle
	write_hold_a: assert property (!we_n && !$past(we_n) |->
		$stable(addr) && $stable(h_dq))
		else $error("write address or data moved under the strobe");
	read_pulse_a: assert property ($fell(oe_n) |->
		(!oe_n && !ce_n && we_n)[*3] ##1 oe_n)
		else $error("read access not three cycles");
	read_gap_a: assert property ($rose(oe_n) |-> oe_n[*2])
		else $error("output enable not released between reads");

	write_seen_c: cover property ($fell(we_n));
	answer_seen_c: cover property ($rose(d_dq_oe));
	limit_seen_c: cover property (d_dq_oe && dq[LIMIT_BIT]);
	toggle_seen_c: cover property ($rose(d_dq_oe) ##[4:8] ($rose(d_dq_oe)
		&& d_dq[6] != $past(d_dq[6], 5)));
endmodule : fbp_checker
`default_nettype wire

/* File: sim/flash_bypass_and_status_poll_bench.sv */
// host and bank joined back to back, driven through host registers
`timescale 1ns/1ns
`default_nettype none
module flash_bypass_and_status_poll_bench;
	import fbp_pkg::*;
	logic i_mclk;
	logic i_rstn;
	logic [3:0] reg_addr;
	logic [DW-1:0] reg_wdata;
	logic reg_wr;
	logic reg_rd;
	logic [DW-1:0] reg_rdata;
	logic [NSEC-1:0] sector_protect;
	logic bypass;
	logic busy;
	logic limit;
	logic [DW-1:0] v;
	int fail_count = 0;
	int check_count = 0;
	int busy_cyc = 0;
	int lim_cyc = 0;
	int b0;

	fbp_if bus_if();
	fbp_flash #(.PROG_CYC(16'h0010), .ERASE_CYC(16'h0040),
		.PROT_PROG_CYC(16'h0008), .ALL_PROT_CYC(16'h0020)) i_fbp_flash (
		.i_mclk(i_mclk), .i_rstn(i_rstn), .bus(bus_if.dev),
		.i_sector_protect(sector_protect), .o_bypass(bypass),
		.o_busy(busy), .o_limit(limit));
	fbp_host i_fbp_host (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.i_reg_addr(reg_addr), .i_reg_wdata(reg_wdata), .i_reg_wr(reg_wr),
		.i_reg_rd(reg_rd), .o_reg_rdata(reg_rdata), .bus(bus_if.host));
	fbp_checker i_fbp_checker (.i_mclk(i_mclk), .i_rstn(i_rstn),
		.addr(bus_if.addr), .ce_n(bus_if.ce_n), .oe_n(bus_if.oe_n),
		.we_n(bus_if.we_n), .h_dq(bus_if.h_dq), .h_dq_oe(bus_if.h_dq_oe),
		.d_dq(bus_if.d_dq), .d_dq_oe(bus_if.d_dq_oe), .dq(bus_if.dq));

	initial begin
		i_mclk = 1'b0;
		forever #5 i_mclk = ~i_mclk;
	end

	// cycle tallies let interval lengths be judged without touching timing
	always @(posedge i_mclk) begin
		if (busy === 1'b1) busy_cyc <= busy_cyc + 1;
		if (limit === 1'b1) lim_cyc <= lim_cyc + 1;
	end

	task automatic end_sim;
		if (fail_count == 0 && check_count > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : end_sim

	task automatic chk(input logic [DW-1:0] got, input logic [DW-1:0] exp);
		check_count++;
		if (got !== exp) begin
			fail_count++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	task automatic reg_write(input logic [3:0] a, input logic [DW-1:0] d);
		@(posedge i_mclk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge i_mclk);
		reg_wr <= 1'b0;
	endtask : reg_write

	// data stands only in the cycle after the strobe
	task automatic reg_read(input logic [3:0] a, output logic [DW-1:0] d);
		@(posedge i_mclk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge i_mclk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : reg_read

	task automatic run(input logic [3:0] op);
		reg_write(REG_CMD, {12'h000, op});
		for (int i = 0; i < 4000; i++) begin
			reg_read(REG_STAT, v);
			if (v[ST_BUSY] === 1'b0) return;
		end
		fail_count++;
		$display("Error at %0t: got %h expected %h", $time, v, 16'h0000);
		end_sim();
	endtask : run

	task automatic prog(input logic [AW-1:0] a, input logic [DW-1:0] d);
		reg_write(REG_ADDR, {4'h0, a});
		reg_write(REG_DATA, d);
		run(OP_PROG);
	endtask : prog

	task automatic erase(input logic [AW-1:0] a);
		reg_write(REG_ADDR, {4'h0, a});
		run(OP_ERASE);
	endtask : erase

	task automatic rd_chk(input logic [AW-1:0] a, input logic [DW-1:0] e);
		reg_write(REG_ADDR, {4'h0, a});
		run(OP_READ);
		reg_read(REG_RDATA, v);
		chk(v, e);
	endtask : rd_chk

	// interval is only roughly fixed, so allow half to double
	task automatic win(input int lo, input int hi);
		chk({15'h0, (busy_cyc - b0 >= lo) && (busy_cyc - b0 <= hi)}, 16'h1);
	endtask : win

	initial begin
		i_rstn = 1'b0;
		reg_addr = 4'h0;
		reg_wdata = 16'h0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		sector_protect = 4'h0;
		repeat (3) @(posedge i_mclk);
		i_rstn <= 1'b1;
		reg_read(REG_STAT, v);
		chk(v, 16'h0000);
		reg_read(4'h5, v);
		chk(v, 16'h0000);
		reg_write(REG_STAT, 16'hffff);
		reg_read(REG_STAT, v);
		chk(v, 16'h0000);
		reg_write(REG_ADDR, 16'h7abc);
		reg_read(REG_ADDR, v);
		chk(v, 16'h0abc);
		chk({15'h0, bypass}, 16'h0000);
		run(OP_ENTER);
		chk({15'h0, bypass}, 16'h0001);
		chk(v, 16'h0002);
		for (int k = 0; k < 2; k++) begin
			run(k ? OP_ENTER : OP_RESET);
			chk({15'h0, bypass}, 16'h0001);
		end
		b0 = busy_cyc;
		prog(12'h001, 16'h1234);
		win(8, 32);
		chk(v, 16'h0002);
		reg_read(REG_RDATA, v);
		chk(v, 16'h1234);
		rd_chk(12'h001, 16'h1234);
		prog(12'h802, 16'h00ff);
		@(posedge i_mclk) sector_protect <= 4'h2;
		b0 = busy_cyc;
		prog(12'h401, 16'h0000);
		win(4, 16);
		rd_chk(12'h401, 16'hffff);
		chk({15'h0, bypass}, 16'h0001);
		@(posedge i_mclk) sector_protect <= 4'h4;
		b0 = busy_cyc;
		erase(12'h800);
		win(16, 64);
		rd_chk(12'h802, 16'h00ff);
		@(posedge i_mclk) sector_protect <= 4'h0;
		b0 = busy_cyc;
		erase(12'h800);
		win(32, 128);
		reg_read(REG_RDATA, v);
		chk(v, 16'hffff);
		rd_chk(12'h802, 16'hffff);
		rd_chk(12'h001, 16'h1234);
		b0 = lim_cyc;
		prog(12'h001, 16'hffff);
		chk(v, 16'h0006);
		chk({15'h0, lim_cyc > b0}, 16'h0001);
		chk({15'h0, bypass}, 16'h0000);
		rd_chk(12'h001, 16'h1234);
		run(OP_ENTER);
		chk({15'h0, bypass}, 16'h0001);
		run(OP_EXIT);
		chk({15'h0, bypass}, 16'h0000);
		chk(v, 16'h0002);
		rd_chk(12'h802, 16'hffff);
		// a reset while in fast mode must drop fast mode and leave the array erased
		run(OP_ENTER);
		@(posedge i_mclk) i_rstn <= 1'b0;
		repeat (2) @(posedge i_mclk);
		i_rstn <= 1'b1;
		chk({15'h0, bypass}, 16'h0000);
		reg_read(REG_STAT, v);
		chk(v, 16'h0000);
		rd_chk(12'h001, 16'hffff);
		end_sim();
	end
endmodule : flash_bypass_and_status_poll_bench
`default_nettype wire
